// file: rtl/desc_dma_regs.svh
// descriptor field positions, list stride and fifo sizing for the packet dma
// assumes 32-bit host memory words and four-word descriptors
`ifndef DESC_DMA_REGS_SVH
`define DESC_DMA_REGS_SVH

// word 0: ownership flag and receive status
`define DESC_OWN_BIT 31
`define RX_STAT_FIRST_BIT 9
`define RX_STAT_LAST_BIT 8
`define RX_LEN_RANGE 29:16
// word 1: control
`define DESC_LAST_SEG_BIT 30
`define DESC_END_RING_BIT 25
`define DESC_CHAIN_BIT 24
`define DESC_B2_RANGE 21:11
`define DESC_B1_RANGE 10:0
// word offsets within a descriptor, ring stride
`define DESC_W1_OFS 32'h0000_0004
`define DESC_W2_OFS 32'h0000_0008
`define DESC_W3_OFS 32'h0000_000C
`define DESC_STRIDE 32'h0000_0010
`define WORD_BYTES 32'h0000_0004
// fifo sizing
`define TX_FIFO_BYTES 2048
`define TX_FIFO_WORDS (`TX_FIFO_BYTES / 4)
`define TX_FIFO_AW 9
`define RX_FIFO_WORDS 8
`define RX_FIFO_AW 3
`define TX_MAX_PKTS 2'h2
`define FIFO_W 33

`endif

// file: rtl/desc_dma_pkg.sv
// state types of the descriptor packet dma
// assumes desc_dma_regs.svh supplies field positions
package desc_dma_pkg;
  typedef enum logic [6:0] {
    TX_IDLE = 7'h01,
    TX_D0 = 7'h02,
    TX_D1 = 7'h04,
    TX_D2 = 7'h08,
    TX_D3 = 7'h10,
    TX_DATA = 7'h20,
    TX_WB = 7'h40
  } tx_state_t;
  typedef enum logic [6:0] {
    RX_IDLE = 7'h01,
    RX_D0 = 7'h02,
    RX_D1 = 7'h04,
    RX_D2 = 7'h08,
    RX_D3 = 7'h10,
    RX_DATA = 7'h20,
    RX_WB = 7'h40
  } rx_state_t;
endpackage

// file: rtl/pkt_fifo.sv
// word fifo with registered read data and registered ready
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module pkt_fifo #(
  parameter int W = 33,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic ready_r, valid_r, push, load;
  logic [W-1:0] data_r;

  // load the output stage when a word is stored and the stage is empty or being drained
  assign push = in_valid && ready_r;
  assign load = (cnt_r != '0) && (!valid_r || out_ready);
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  assign in_ready = ready_r;
  assign out_data = data_r;
  assign out_valid = valid_r;

  // storage; no reset so it maps onto ram
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill level; ready is a flop so the source sees no comb path
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (load) rd_ptr_r <= rd_ptr_r + 1'b1;
      cnt_r <= cnt_nxt;
      ready_r <= cnt_nxt != (AW+1)'(D);
    end
  end

  // output register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      valid_r <= 1'b0;
      data_r <= '0;
    end else if (load) begin
      valid_r <= 1'b1;
      data_r <= mem_r[rd_ptr_r];
    end else if (out_ready) begin
      valid_r <= 1'b0;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cnt_r <= (AW+1)'(D)) else $error("fifo level above depth");
endmodule // pkt_fifo

// file: rtl/desc_dma.sv
// descriptor driven packet dma between host memory and mac fifos
// assumes a single-outstanding memory port: mem_req held until mem_ack,
// read data valid with mem_ack; host software builds descriptor lists
`timescale 1ns/1ps
`include "desc_dma_regs.svh"

module desc_dma (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic tx_start,
  input wire logic [31:0] tx_list_base,
  input wire logic tx_poll,
  input wire logic rx_start,
  input wire logic [31:0] rx_list_base,
  input wire logic rx_poll,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic [31:0] tx_data,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic rx_early
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  function automatic logic [9:0] words(input logic [10:0] sz);
    logic [11:0] s;
    s = {1'b0, sz} + 12'h003;
    return s[11:2];
  endfunction

  // memory port
  logic mem_req_r, mem_we_r, own_rx_r;
  logic [31:0] mem_addr_r, mem_wdata_r;
  logic tx_done, rx_done;
  // transmit engine
  desc_dma_pkg::tx_state_t tx_st_r;
  logic [31:0] tx_base_r, tx_desc_r, tx_ctl_r, tx_buf1_r, tx_next_r, tx_addr_r, tx_maddr_r;
  logic [9:0] tx_cnt_r, tx_w2;
  logic tx_bsel_r, tx_req_r, tx_we_r, tx_push, tx_push_last, tx_in_ready;
  logic [1:0] tx_pkts_r;
  logic [`FIFO_W-1:0] tx_fifo_out;
  // receive engine
  desc_dma_pkg::rx_state_t rx_st_r;
  logic [31:0] rx_base_r, rx_desc_r, rx_ctl_r, rx_buf1_r, rx_next_r, rx_addr_r, rx_maddr_r;
  logic [31:0] rx_wdata_r;
  logic [9:0] rx_cnt_r, rx_w2;
  logic [13:0] rx_len_r;
  logic rx_bsel_r, rx_req_r, rx_we_r, rx_end_r, rx_first_r, rx_early_r, rx_pop;
  logic [`FIFO_W-1:0] rx_fifo_out;
  logic rx_fifo_valid;

  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;
  assign rx_early = rx_early_r;
  assign tx_data = tx_fifo_out[31:0];
  assign tx_last = tx_fifo_out[32];
  assign tx_done = mem_req_r && mem_ack && !own_rx_r;
  assign rx_done = mem_req_r && mem_ack && own_rx_r;

  // shared port, one access at a time; receive first since its fifo is small
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      own_rx_r <= 1'b0;
      mem_addr_r <= 32'h0000_0000;
      mem_wdata_r <= 32'h0000_0000;
    end else if (!mem_req_r) begin
      if (rx_req_r) begin
        mem_req_r <= 1'b1;
        own_rx_r <= 1'b1;
        mem_we_r <= rx_we_r;
        mem_addr_r <= rx_maddr_r;
        mem_wdata_r <= rx_wdata_r;
      end else if (tx_req_r) begin
        mem_req_r <= 1'b1;
        own_rx_r <= 1'b0;
        mem_we_r <= tx_we_r;
        mem_addr_r <= tx_maddr_r;
        mem_wdata_r <= 32'h0000_0000; // tx writes only hand back ownership
      end
    end else if (mem_ack) begin
      mem_req_r <= 1'b0;
    end
  end

  // transmit: second buffer only exists in ring mode
  assign tx_w2 = tx_ctl_r[`DESC_CHAIN_BIT] ? 10'h000 : words(tx_ctl_r[`DESC_B2_RANGE]);
  assign tx_push = (tx_st_r == desc_dma_pkg::TX_DATA) && tx_done;
  // last word of the packet closes the fifo entry, so no buffer mixes packets
  assign tx_push_last = tx_ctl_r[`DESC_LAST_SEG_BIT] && (tx_cnt_r == 10'h001)
    && (tx_bsel_r || tx_w2 == 10'h000);

  // transmit descriptor walk
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_st_r <= desc_dma_pkg::TX_IDLE;
      tx_base_r <= 32'h0000_0000;
      tx_desc_r <= 32'h0000_0000;
      tx_ctl_r <= 32'h0000_0000;
      tx_buf1_r <= 32'h0000_0000;
      tx_next_r <= 32'h0000_0000;
      tx_addr_r <= 32'h0000_0000;
      tx_maddr_r <= 32'h0000_0000;
      tx_cnt_r <= 10'h000;
      tx_bsel_r <= 1'b0;
      tx_req_r <= 1'b0;
      tx_we_r <= 1'b0;
    end else begin
      unique case (tx_st_r)
        desc_dma_pkg::TX_IDLE: begin
          if (tx_start) begin
            tx_base_r <= tx_list_base;
            tx_desc_r <= tx_list_base;
            tx_st_r <= desc_dma_pkg::TX_D0;
          end else if (tx_poll) begin
            tx_st_r <= desc_dma_pkg::TX_D0;
          end
        end
        desc_dma_pkg::TX_D0: begin
          // hold off the next descriptor while two packets wait
          if (!tx_req_r && tx_pkts_r < `TX_MAX_PKTS) begin
            tx_req_r <= 1'b1;
            tx_maddr_r <= tx_desc_r;
          end else if (tx_done) begin
            if (!mem_rdata[`DESC_OWN_BIT]) begin
              tx_req_r <= 1'b0;
              tx_st_r <= desc_dma_pkg::TX_IDLE;
            end else begin
              tx_maddr_r <= tx_desc_r + `DESC_W1_OFS;
              tx_st_r <= desc_dma_pkg::TX_D1;
            end
          end
        end
        desc_dma_pkg::TX_D1: begin
          if (tx_done) begin
            tx_ctl_r <= mem_rdata;
            tx_maddr_r <= tx_desc_r + `DESC_W2_OFS;
            tx_st_r <= desc_dma_pkg::TX_D2;
          end
        end
        desc_dma_pkg::TX_D2: begin
          if (tx_done) begin
            tx_buf1_r <= mem_rdata;
            tx_maddr_r <= tx_desc_r + `DESC_W3_OFS;
            tx_st_r <= desc_dma_pkg::TX_D3;
          end
        end
        desc_dma_pkg::TX_D3: begin
          if (tx_done) begin
            tx_next_r <= mem_rdata;
            tx_req_r <= 1'b0;
            tx_bsel_r <= 1'b0;
            tx_addr_r <= tx_buf1_r;
            tx_cnt_r <= words(tx_ctl_r[`DESC_B1_RANGE]);
            tx_st_r <= desc_dma_pkg::TX_DATA;
          end
        end
        desc_dma_pkg::TX_DATA: begin
          if (tx_cnt_r == 10'h000) begin
            if (!tx_bsel_r && tx_w2 != 10'h000) begin
              tx_bsel_r <= 1'b1;
              tx_addr_r <= tx_next_r;
              tx_cnt_r <= tx_w2;
            end else begin
              tx_st_r <= desc_dma_pkg::TX_WB;
            end
          end else if (!tx_req_r && tx_in_ready) begin
            // only issued with room, so the pushed word always fits
            tx_req_r <= 1'b1;
            tx_maddr_r <= tx_addr_r;
          end else if (tx_done) begin
            tx_req_r <= 1'b0;
            tx_addr_r <= tx_addr_r + `WORD_BYTES;
            tx_cnt_r <= tx_cnt_r - 10'h001;
          end
        end
        desc_dma_pkg::TX_WB: begin
          if (!tx_req_r) begin
            tx_req_r <= 1'b1;
            tx_we_r <= 1'b1;
            tx_maddr_r <= tx_desc_r;
          end else if (tx_done) begin
            tx_req_r <= 1'b0;
            tx_we_r <= 1'b0;
            if (tx_ctl_r[`DESC_CHAIN_BIT]) tx_desc_r <= tx_next_r;
            else if (tx_ctl_r[`DESC_END_RING_BIT]) tx_desc_r <= tx_base_r;
            else tx_desc_r <= tx_desc_r + `DESC_STRIDE;
            tx_st_r <= desc_dma_pkg::TX_D0;
          end
        end
      endcase
    end
  end

  // whole packets held in the transmit fifo
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_pkts_r <= 2'h0;
    end else begin
      tx_pkts_r <= tx_pkts_r + {1'b0, tx_push && tx_push_last}
        - {1'b0, tx_valid && tx_ready && tx_last};
    end
  end

  // 2 kbyte transmit fifo; fetch runs ahead of the mac for back to back sends
  pkt_fifo #(.W(`FIFO_W), .D(`TX_FIFO_WORDS), .AW(`TX_FIFO_AW)) u_tx_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_data({tx_push_last, mem_rdata}),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .out_data(tx_fifo_out),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // receive fifo; rx_ready back-pressures the mac
  pkt_fifo #(.W(`FIFO_W), .D(`RX_FIFO_WORDS), .AW(`RX_FIFO_AW)) u_rx_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_data({rx_last, rx_data}),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(rx_fifo_out),
    .out_valid(rx_fifo_valid),
    .out_ready(rx_pop)
  );

  assign rx_w2 = rx_ctl_r[`DESC_CHAIN_BIT] ? 10'h000 : words(rx_ctl_r[`DESC_B2_RANGE]);
  // take a word only when stored and not after the packet end: one packet per buffer
  assign rx_pop = (rx_st_r == desc_dma_pkg::RX_DATA) && !rx_req_r && !rx_end_r
    && (rx_cnt_r != 10'h000) && rx_fifo_valid;

  // receive descriptor walk
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_st_r <= desc_dma_pkg::RX_IDLE;
      rx_base_r <= 32'h0000_0000;
      rx_desc_r <= 32'h0000_0000;
      rx_ctl_r <= 32'h0000_0000;
      rx_buf1_r <= 32'h0000_0000;
      rx_next_r <= 32'h0000_0000;
      rx_addr_r <= 32'h0000_0000;
      rx_maddr_r <= 32'h0000_0000;
      rx_wdata_r <= 32'h0000_0000;
      rx_cnt_r <= 10'h000;
      rx_len_r <= 14'h0000;
      rx_bsel_r <= 1'b0;
      rx_req_r <= 1'b0;
      rx_we_r <= 1'b0;
      rx_end_r <= 1'b0;
      rx_first_r <= 1'b1;
      rx_early_r <= 1'b0;
    end else begin
      rx_early_r <= 1'b0;
      unique case (rx_st_r)
        desc_dma_pkg::RX_IDLE: begin
          if (rx_start) begin
            rx_base_r <= rx_list_base;
            rx_desc_r <= rx_list_base;
            rx_st_r <= desc_dma_pkg::RX_D0;
          end else if (rx_poll) begin
            rx_st_r <= desc_dma_pkg::RX_D0;
          end
        end
        desc_dma_pkg::RX_D0: begin
          if (!rx_req_r) begin
            rx_req_r <= 1'b1;
            rx_maddr_r <= rx_desc_r;
          end else if (rx_done) begin
            if (!mem_rdata[`DESC_OWN_BIT]) begin
              rx_req_r <= 1'b0;
              rx_st_r <= desc_dma_pkg::RX_IDLE;
            end else begin
              rx_maddr_r <= rx_desc_r + `DESC_W1_OFS;
              rx_st_r <= desc_dma_pkg::RX_D1;
            end
          end
        end
        desc_dma_pkg::RX_D1: begin
          if (rx_done) begin
            rx_ctl_r <= mem_rdata;
            rx_maddr_r <= rx_desc_r + `DESC_W2_OFS;
            rx_st_r <= desc_dma_pkg::RX_D2;
          end
        end
        desc_dma_pkg::RX_D2: begin
          if (rx_done) begin
            rx_buf1_r <= mem_rdata;
            rx_maddr_r <= rx_desc_r + `DESC_W3_OFS;
            rx_st_r <= desc_dma_pkg::RX_D3;
          end
        end
        desc_dma_pkg::RX_D3: begin
          if (rx_done) begin
            rx_next_r <= mem_rdata;
            rx_req_r <= 1'b0;
            rx_bsel_r <= 1'b0;
            rx_addr_r <= rx_buf1_r;
            rx_cnt_r <= words(rx_ctl_r[`DESC_B1_RANGE]);
            rx_st_r <= desc_dma_pkg::RX_DATA;
          end
        end
        desc_dma_pkg::RX_DATA: begin
          if (rx_end_r && !rx_req_r) begin
            rx_st_r <= desc_dma_pkg::RX_WB;
          end else if (rx_cnt_r == 10'h000 && !rx_req_r) begin
            if (!rx_bsel_r && rx_w2 != 10'h000) begin
              rx_bsel_r <= 1'b1;
              rx_addr_r <= rx_next_r;
              rx_cnt_r <= rx_w2;
              rx_early_r <= rx_first_r;
            end else begin
              rx_st_r <= desc_dma_pkg::RX_WB;
            end
          end else if (rx_pop) begin
            rx_req_r <= 1'b1;
            rx_we_r <= 1'b1;
            rx_maddr_r <= rx_addr_r;
            rx_wdata_r <= rx_fifo_out[31:0];
            rx_end_r <= rx_fifo_out[32];
          end else if (rx_done) begin
            rx_req_r <= 1'b0;
            rx_we_r <= 1'b0;
            rx_addr_r <= rx_addr_r + `WORD_BYTES;
            rx_cnt_r <= rx_cnt_r - 10'h001;
            rx_len_r <= rx_len_r + 14'h0004;
          end
        end
        desc_dma_pkg::RX_WB: begin
          if (!rx_req_r) begin
            rx_req_r <= 1'b1;
            rx_we_r <= 1'b1;
            rx_maddr_r <= rx_desc_r;
            rx_wdata_r <= 32'h0000_0000;
            rx_wdata_r[`RX_LEN_RANGE] <= rx_len_r;
            rx_wdata_r[`RX_STAT_FIRST_BIT] <= rx_first_r;
            rx_wdata_r[`RX_STAT_LAST_BIT] <= rx_end_r;
          end else if (rx_done) begin
            rx_req_r <= 1'b0;
            rx_we_r <= 1'b0;
            rx_first_r <= rx_end_r;
            rx_end_r <= 1'b0;
            if (rx_end_r) rx_len_r <= 14'h0000;
            if (rx_ctl_r[`DESC_CHAIN_BIT]) rx_desc_r <= rx_next_r;
            else if (rx_ctl_r[`DESC_END_RING_BIT]) rx_desc_r <= rx_base_r;
            else rx_desc_r <= rx_desc_r + `DESC_STRIDE;
            rx_st_r <= desc_dma_pkg::RX_D0;
          end
        end
      endcase
    end
  end

  a_tx_own_stop: assert property ((tx_st_r == desc_dma_pkg::TX_D0 && tx_done
    && !mem_rdata[`DESC_OWN_BIT]) |=> tx_st_r == desc_dma_pkg::TX_IDLE && !mem_req)
    else $error("tx did not stop on host-owned descriptor");
  a_tx_own_clear: assert property ((mem_req && mem_we && !own_rx_r)
    |-> !mem_wdata[`DESC_OWN_BIT] && mem_addr == tx_desc_r)
    else $error("tx hand back does not clear ownership");
  a_rx_own_clear: assert property ((rx_st_r == desc_dma_pkg::RX_WB && rx_done)
    |-> !mem_wdata[`DESC_OWN_BIT] && mem_addr == rx_desc_r)
    else $error("rx hand back does not clear ownership");
  a_chain_one_buf: assert property ((tx_st_r == desc_dma_pkg::TX_DATA
    && tx_ctl_r[`DESC_CHAIN_BIT]) |-> !tx_bsel_r)
    else $error("chain descriptor used a second buffer");
  a_ring_two_bufs: assert property ((tx_st_r == desc_dma_pkg::TX_DATA
    && tx_cnt_r == 10'h000 && !tx_bsel_r && tx_w2 != 10'h000)
    |=> tx_bsel_r && tx_cnt_r == $past(tx_w2) && tx_addr_r == tx_next_r)
    else $error("ring second buffer skipped");
  a_pkt_limit_hold: assert property ((tx_st_r == desc_dma_pkg::TX_D0
    && !tx_req_r && tx_pkts_r == `TX_MAX_PKTS) |=> !tx_req_r)
    else $error("descriptor fetched with two packets queued");
  a_ring_advance: assert property ((tx_st_r == desc_dma_pkg::TX_WB && tx_done
    && !tx_ctl_r[`DESC_CHAIN_BIT] && !tx_ctl_r[`DESC_END_RING_BIT])
    |=> tx_desc_r == $past(tx_desc_r) + `DESC_STRIDE)
    else $error("ring did not advance by one descriptor");
  a_mem_req_hold: assert property ((mem_req && !mem_ack)
    |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped before ack");
  a_rx_pop_write: assert property (rx_pop
    |=> rx_req_r && rx_we_r && rx_wdata_r == $past(rx_fifo_out[31:0]))
    else $error("popped rx word not written");
  a_rx_early_ring: assert property (rx_early
    |-> !rx_ctl_r[`DESC_CHAIN_BIT] && rx_bsel_r)
    else $error("early event outside ring mode");
endmodule // desc_dma

// file: verification/host_mem_model.sv
// host memory model answering the dma memory port
// assumes addresses below 1 KB; the bench builds descriptor lists in mem directly
`timescale 1ns/1ps
module host_mem_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [1:0] lat,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:255]; // descriptors and buffers
  logic [1:0] wait_r;

  // one access at a time, answered after lat waiting cycles
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // read data never lingers between answers
    if (sys_rst) begin
      wait_r <= 2'h0;
      mem_rdata <= 32'h0F0F_0F0F;
    end else if (mem_req && !mem_ack) begin
      if (wait_r == lat) begin
        wait_r <= 2'h0;
        mem_ack <= 1'b1;
        if (mem_we)
          mem[mem_addr[9:2]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[9:2]];
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule // host_mem_model

// file: verification/descriptor_packet_dma_tb_top.sv
// self-checking bench for the descriptor packet dma
// assumes host_mem_model as host memory and the bench as the mac on both streams
`timescale 1ns/1ps
module descriptor_packet_dma_tb_top;
  logic sys_clk, sys_rst, tx_start, tx_poll, rx_start, rx_poll, mem_req, mem_we, mem_ack;
  logic tx_last, tx_valid, tx_ready, rx_last, rx_valid, rx_ready, rx_early;
  logic [31:0] tx_list_base, rx_list_base, mem_addr, mem_wdata, mem_rdata, tx_data, rx_data;
  logic [1:0] lat;
  logic [32:0] txq [$];
  int stamp [$];
  int failures = 0, cmp_count = 0, cyc = 0, early_cnt = 0;

  desc_dma dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .tx_start(tx_start),
    .tx_list_base(tx_list_base), .tx_poll(tx_poll), .rx_start(rx_start),
    .rx_list_base(rx_list_base), .rx_poll(rx_poll), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_early(rx_early));
  host_mem_model hm (.sys_clk(sys_clk), .sys_rst(sys_rst), .lat(lat), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // mac sink with arrival stamps, early event counter
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (tx_valid === 1'b1 && tx_ready) begin
      txq.push_back({tx_last, tx_data});
      stamp.push_back(cyc);
    end
    if (rx_early === 1'b1) early_cnt <= early_cnt + 1;
  end

  task automatic end_of_test;
    $display("counts: %0d compared, %0d failed", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    failures++;
    $display("Error %s expected done seen timeout", what);
    end_of_test;
  endtask

  // buffer contents are a fixed pattern of the word index
  function automatic logic [31:0] bw(input logic [31:0] a);
    return 32'hB000_0000 + {22'h0, a[9:2]};
  endfunction

  // four-word descriptor; ctl is last segment, end of ring, chain
  task automatic desc(input logic [31:0] a, input logic own, input logic [2:0] ctl,
      input logic [10:0] b2, input logic [10:0] b1, input logic [31:0] p2,
      input logic [31:0] p3);
    hm.mem[a[9:2]] = {own, 31'h0};
    hm.mem[a[9:2] + 8'h1] = {1'b0, ctl[2], 4'h0, ctl[1:0], 2'h0, b2, b1};
    hm.mem[a[9:2] + 8'h2] = p2;
    hm.mem[a[9:2] + 8'h3] = p3;
  endtask

  task automatic wait_tx(input int n);
    int i;
    for (i = 0; i < 3000 && txq.size() < n; i++) @(posedge sys_clk);
    if (txq.size() < n) hang("tx words");
  endtask

  task automatic tx_word(input logic [31:0] d, input logic l);
    chk("tx word", {l, d}, txq.pop_front());
  endtask

  // polls memory until the write lands, bounded
  task automatic mem_is(input string what, input logic [31:0] a, input logic [31:0] d);
    int i;
    for (i = 0; i < 3000 && hm.mem[a[9:2]] !== d; i++) @(posedge sys_clk);
    chk(what, {1'b0, d}, {1'b0, hm.mem[a[9:2]]});
    if (hm.mem[a[9:2]] !== d) end_of_test;
  endtask

  // data is scrambled once taken so a stale word never looks valid
  task automatic rx_word(input logic [31:0] d, input logic l);
    int i;
    @(posedge sys_clk);
    rx_data <= d;
    rx_last <= l;
    rx_valid <= 1'b1;
    for (i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      if (rx_ready === 1'b1) break;
    end
    rx_valid <= 1'b0;
    rx_data <= ~d;
    if (i == 3000) hang("rx take");
  endtask

  task automatic pulse(input logic is_tx, input logic poll);
    @(posedge sys_clk);
    tx_start <= is_tx & !poll;
    tx_poll <= is_tx & poll;
    rx_start <= !is_tx & !poll;
    rx_poll <= !is_tx & poll;
    @(posedge sys_clk);
    tx_start <= 1'b0;
    tx_poll <= 1'b0;
    rx_start <= 1'b0;
    rx_poll <= 1'b0;
  endtask

  task automatic tx_ring_test;
    desc(32'h0, 1'b1, 3'h4, 11'h4, 11'h8, 32'h100, 32'h140);
    hm.mem[4] = 32'h0;
    tx_list_base <= 32'h0;
    pulse(1'b1, 1'b0);
    wait_tx(3);
    tx_word(bw(32'h100), 1'b0);
    tx_word(bw(32'h104), 1'b0);
    tx_word(bw(32'h140), 1'b1);
    mem_is("tx desc0 word0", 32'h0, 32'h0);
    repeat (80) @(posedge sys_clk);
    chk("tx words while host owns", 33'h0, 33'(txq.size()));
    desc(32'h10, 1'b1, 3'h6, 11'h0, 11'h4, 32'h150, 32'h0);
    pulse(1'b1, 1'b1);
    wait_tx(1);
    tx_word(bw(32'h150), 1'b1);
    mem_is("tx desc1 word0", 32'h10, 32'h0);
    $display("done tx ring");
  endtask

  // mac stalls so two packets pile up, then drains back to back
  task automatic tx_chain_test;
    // start is only taken in idle; let the last host-owned read finish first
    repeat (20) @(posedge sys_clk);
    lat <= 2'h2;
    tx_ready <= 1'b0;
    txq.delete();
    stamp.delete();
    desc(32'h20, 1'b1, 3'h5, 11'h4, 11'h4, 32'h180, 32'h60);
    desc(32'h60, 1'b1, 3'h5, 11'h4, 11'h4, 32'h184, 32'h40);
    desc(32'h40, 1'b1, 3'h5, 11'h4, 11'h4, 32'h188, 32'h70);
    hm.mem[28] = 32'h0;
    tx_list_base <= 32'h20;
    pulse(1'b1, 1'b0);
    repeat (300) @(posedge sys_clk);
    chk("third desc untouched", 33'h8000_0000, {1'b0, hm.mem[16]});
    chk("tx waiting", 33'h1, {32'h0, tx_valid});
    tx_ready <= 1'b1;
    wait_tx(3);
    chk("tx spacing", 33'h1, 33'(stamp[1] - stamp[0]));
    tx_word(bw(32'h180), 1'b1);
    tx_word(bw(32'h184), 1'b1);
    tx_word(bw(32'h188), 1'b1);
    mem_is("tx chain desc word0", 32'h40, 32'h0);
    $display("done tx chain");
  endtask

  task automatic rx_ring_test;
    int e0;
    e0 = early_cnt;
    lat <= 2'h0;
    desc(32'h80, 1'b1, 3'h0, 11'h4, 11'h4, 32'h200, 32'h204);
    desc(32'h90, 1'b1, 3'h2, 11'h0, 11'h8, 32'h210, 32'h0);
    rx_list_base <= 32'h80;
    pulse(1'b0, 1'b0);
    rx_word(32'hC000_0000, 1'b0);
    rx_word(32'hC000_0001, 1'b0);
    rx_word(32'hC000_0002, 1'b1);
    mem_is("rx status 0", 32'h80, 32'h0008_0200);
    mem_is("rx status 1", 32'h90, 32'h000C_0100);
    chk("rx buf1", 33'h0_C000_0000, {1'b0, hm.mem[128]});
    chk("rx buf2", 33'h0_C000_0001, {1'b0, hm.mem[129]});
    chk("rx next buf", 33'h0_C000_0002, {1'b0, hm.mem[132]});
    chk("rx early count", 33'h1, 33'(early_cnt - e0));
    // chain list resumed by poll: second word follows the link, not buffer 2
    repeat (20) @(posedge sys_clk);
    desc(32'hC0, 1'b1, 3'h1, 11'h4, 11'h4, 32'h230, 32'hD0);
    hm.mem[52] = 32'h0;
    desc(32'h80, 1'b1, 3'h1, 11'h4, 11'h4, 32'h220, 32'hC0);
    pulse(1'b0, 1'b1);
    rx_word(32'hC000_0003, 1'b0);
    rx_word(32'hC000_0004, 1'b1);
    mem_is("rx chain status 0", 32'h80, 32'h0004_0200);
    mem_is("rx chain status 1", 32'hC0, 32'h0008_0100);
    chk("rx chain buf 0", 33'h0_C000_0003, {1'b0, hm.mem[136]});
    chk("rx chain buf 1", 33'h0_C000_0004, {1'b0, hm.mem[140]});
    $display("done rx ring");
  endtask

  initial begin
    sys_rst = 1'b1;
    {tx_start, tx_poll, rx_start, rx_poll, rx_last, rx_valid} = 6'h0;
    tx_ready = 1'b1;
    lat = 2'h1;
    tx_list_base = 32'h0;
    rx_list_base = 32'h0;
    rx_data = 32'h0;
    for (int i = 0; i < 256; i++) hm.mem[i] = 32'hB000_0000 + i;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tx_ring_test();
    tx_chain_test();
    rx_ring_test();
    end_of_test();
  end
endmodule // descriptor_packet_dma_tb_top
